// file: include/baud_gen_pkg.sv
// Constants, mode encoding and state layout of the baud generator block
package baud_gen_pkg;
	localparam logic [15:0] ADDR_ASYNC_MODE  = 16'hFF70;
	localparam logic [15:0] ADDR_SYNC_MODE   = 16'hFF72;
	localparam logic [15:0] ADDR_BAUD_SRC    = 16'hFF73;
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam int          TX_EN_BIT        = 7;
	localparam int          RX_EN_BIT        = 6;
	localparam int          THREE_WIRE_BIT   = 7;
	localparam int          BIT_ORDER_BIT    = 2;
	localparam int          CLK_SEL_BIT      = 1;
	localparam int          SRC_SEL_LSB      = 4;
	localparam logic [3:0]  SRC_EXT_PIN      = 4'h8;
	localparam logic [3:0]  SRC_LAST_INT     = 4'h7;
	localparam logic [3:0]  X16_LAST         = 4'hF;
	localparam logic [7:0]  PRESCALE_RESET   = 8'h00;
	localparam logic [2:0]  SYNC_RESET       = 3'h0;
	// Serial clock pin idles high; a zero image would fake an edge at reset
	localparam logic [2:0]  SCK_SYNC_RESET   = 3'h7;

	typedef enum logic [2:0] {
		MODE_STOPPED    = 3'b001,
		MODE_UART       = 3'b010,
		MODE_THREE_WIRE = 3'b100
	} serial_mode_t;

	typedef struct packed {
		logic [7:0]   async_mode;
		logic [7:0]   sync_mode;
		logic [7:0]   baud_src;
		serial_mode_t mode;
		logic [7:0]   prescale;
		logic [2:0]   ext_sync;
		logic [2:0]   sck_sync;
		logic [3:0]   x16_count;
		logic         sck;
		logic         x16_tick;
		logic         bit_tick;
		logic         sck_rise;
		logic         sck_fall;
		logic [7:0]   rd_data;
	} state_t;

	localparam state_t STATE_RESET = '{
		async_mode: REG_RESET, sync_mode: REG_RESET, baud_src: REG_RESET,
		mode: MODE_STOPPED, prescale: PRESCALE_RESET,
		ext_sync: SYNC_RESET, sck_sync: SCK_SYNC_RESET, x16_count: 4'h0,
		sck: 1'b1, x16_tick: 1'b0, bit_tick: 1'b0, sck_rise: 1'b0,
		sck_fall: 1'b0, rd_data: REG_RESET
	};
endpackage : baud_gen_pkg

// file: rtl/serial_baud_gen_and_mode_ctrl.sv
// Baud and serial clock generator with mode control registers
`timescale 1ns/1ps

// Rules of the document for this block and its software
// R1 - Baud source select takes byte writes only, clears to zero at reset.
// R2 - Source codes 0..7 pick system clock divided by 2 to n, n=code+1.
// R3 - Source code 1000 feeds the external async clock pin to the divider.
// R4 - Software uses only the nine defined codes, low nibble kept zero.
// R5 - External async clock works in UART mode only, never in 3-wire.
// R6 - Software never rewrites the source select during a transfer.
// R7 - Software avoids n=1 in UART mode above 3 MHz system clock.
// R8 - UART rate from system clock is fx over 2^(n+1) over 8.
// R9 - UART rate from the external pin is pin frequency over 16.
// R10 - Internal 3-wire serial clock is fx over 2^(n+1).
// R11 - External 3-wire serial clock ignores the source select setting.
// R12 - Exactly three modes: stopped, UART, 3-wire.
// R13 - Stopped mode does no transfers and releases the serial pins.
// R14 - Sync mode register resets to zero, bit or byte writes, bit7 enables.
// R15 - Software keeps sync mode bits 0 and 3 to 6 at zero.
// R16 - Async mode register resets zero, bit7 enables transmit, bit6 receive.
// R17 - Software keeps async mode bits 0 and 1 at zero.
// R18 - UART moves one byte per start bit, transmit and receive together.
// R19 - A 500 kHz pin clock over 16 gives 31.25 kbps for MIDI.
// R20 - Software sets the shared clock pin as input when using it.
// R21 - 3-wire clock select: clear takes pin clock, set takes generator.
// R22 - Divided clocks are one-cycle enables in the system clock domain.
module serial_baud_gen_and_mode_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_wr_bit,
	input  wire logic [2:0]  reg_bit_idx,
	input  wire logic [7:0]  reg_wr_data,
	input  wire logic        reg_rd_en,
	output logic      [7:0]  reg_rd_data,
	input  wire logic        ext_async_clock_pin,
	input  wire logic        sck_pin_in,
	output logic             sck_pin_out,
	output logic             sck_pin_oe_n,
	output logic             uart_x16_tick,
	output logic             uart_bit_tick,
	output logic             sck_rise_tick,
	output logic             sck_fall_tick,
	output logic             transmit_enable,
	output logic             receive_enable,
	output logic             first_bit_lsb,
	output logic             port_release,
	output logic      [2:0]  serial_mode
);
	baud_gen_pkg::state_t st_q;
	baud_gen_pkg::state_t st_d;
	logic [3:0] src_code;
	logic       int_tick;
	logic       ext_edge;
	logic       sck_edge;
	logic       clk_sel_int;

	// Mask of the low n prescaler bits; all ones there marks fx/2^n
	function automatic logic [7:0] src_mask(input logic [3:0] code);
		src_mask = 8'hFF >> (3'h7 - code[2:0]);
	endfunction : src_mask

	// Byte write or single-bit write of a stored register
	function automatic logic [7:0] reg_update(
		input logic [7:0] old,
		input logic       bit_wr,
		input logic [2:0] idx,
		input logic [7:0] data
	);
		reg_update = old;
		if (bit_wr) begin
			reg_update[idx] = data[0];
		end else begin
			reg_update = data;
		end
	endfunction : reg_update

	assign src_code    = st_q.baud_src[baud_gen_pkg::SRC_SEL_LSB +: 4];
	assign clk_sel_int = st_q.sync_mode[baud_gen_pkg::CLK_SEL_BIT];
	assign int_tick    = (src_code <= baud_gen_pkg::SRC_LAST_INT) &&
		((st_q.prescale & src_mask(src_code)) == src_mask(src_code)); // R2
	// Edge detectors read only the second and third synchroniser stages
	assign ext_edge    = st_q.ext_sync[1] & ~st_q.ext_sync[2];
	assign sck_edge    = st_q.sck_sync[1] & ~st_q.sck_sync[2];

	// Next-state logic: registers, mode decode and clock enables
	always_comb begin
		st_d = st_q;
		st_d.prescale = st_q.prescale + 8'h01;
		st_d.ext_sync = {st_q.ext_sync[1:0], ext_async_clock_pin};
		st_d.sck_sync = {st_q.sck_sync[1:0], sck_pin_in};
		st_d.x16_tick = 1'b0;
		st_d.bit_tick = 1'b0;
		st_d.sck_rise = 1'b0;
		st_d.sck_fall = 1'b0;
		st_d.rd_data  = baud_gen_pkg::REG_RESET;

		// Register writes; bit writes to the source select are dropped
		if (reg_wr_en) begin
			case (reg_addr)
				baud_gen_pkg::ADDR_ASYNC_MODE: begin
					st_d.async_mode = reg_update(st_q.async_mode, reg_wr_bit,
						reg_bit_idx, reg_wr_data); // R16
				end
				baud_gen_pkg::ADDR_SYNC_MODE: begin
					st_d.sync_mode = reg_update(st_q.sync_mode, reg_wr_bit,
						reg_bit_idx, reg_wr_data); // R14
				end
				baud_gen_pkg::ADDR_BAUD_SRC: begin
					if (!reg_wr_bit) begin
						st_d.baud_src = reg_wr_data; // R1
					end
				end
				default: begin
				end
			endcase
		end

		// Registered read; unmapped addresses answer zero
		if (reg_rd_en) begin
			case (reg_addr)
				baud_gen_pkg::ADDR_ASYNC_MODE: st_d.rd_data = st_q.async_mode;
				baud_gen_pkg::ADDR_SYNC_MODE:  st_d.rd_data = st_q.sync_mode;
				baud_gen_pkg::ADDR_BAUD_SRC:   st_d.rd_data = st_q.baud_src;
				default:                       st_d.rd_data = 8'h00;
			endcase
		end

		// Mixed enables are prohibited settings and fall back to stopped
		if (st_q.sync_mode[baud_gen_pkg::THREE_WIRE_BIT] &&
			!st_q.async_mode[baud_gen_pkg::TX_EN_BIT] &&
			!st_q.async_mode[baud_gen_pkg::RX_EN_BIT]) begin
			st_d.mode = baud_gen_pkg::MODE_THREE_WIRE; // R12
		end else if (!st_q.sync_mode[baud_gen_pkg::THREE_WIRE_BIT] &&
			(st_q.async_mode[baud_gen_pkg::TX_EN_BIT] ||
			st_q.async_mode[baud_gen_pkg::RX_EN_BIT])) begin
			st_d.mode = baud_gen_pkg::MODE_UART; // R12
		end else begin
			st_d.mode = baud_gen_pkg::MODE_STOPPED; // R12
		end

		// Clock enables per mode; no gated clocks leave this block
		case (st_q.mode)
			baud_gen_pkg::MODE_UART: begin
				st_d.sck = 1'b1;
				if (src_code == baud_gen_pkg::SRC_EXT_PIN) begin
					st_d.x16_tick = ext_edge; // R3 R9 R19
				end else begin
					st_d.x16_tick = int_tick; // R8 R22
				end
				if (st_d.x16_tick) begin
					st_d.x16_count = st_q.x16_count + 4'h1;
					st_d.bit_tick  = (st_q.x16_count ==
						baud_gen_pkg::X16_LAST); // R18
				end
			end
			baud_gen_pkg::MODE_THREE_WIRE: begin
				st_d.x16_count = 4'h0;
				if (clk_sel_int) begin
					// Pin clock code yields no internal tick here
					if (int_tick) begin
						st_d.sck      = ~st_q.sck; // R10 R5
						st_d.sck_rise = ~st_q.sck;
						st_d.sck_fall = st_q.sck;
					end
				end else begin
					st_d.sck      = 1'b1;
					st_d.sck_rise = sck_edge; // R21 R11
					st_d.sck_fall = st_q.sck_sync[2] & ~st_q.sck_sync[1];
				end
			end
			default: begin
				st_d.sck       = 1'b1; // R13
				st_d.x16_count = 4'h0;
			end
		endcase
	end

	// State register; reset loads only the constant reset image
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= baud_gen_pkg::STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops or simple mode decode
	assign reg_rd_data     = st_q.rd_data;
	assign uart_x16_tick   = st_q.x16_tick;
	assign uart_bit_tick   = st_q.bit_tick;
	assign sck_rise_tick   = st_q.sck_rise;
	assign sck_fall_tick   = st_q.sck_fall;
	assign sck_pin_out     = st_q.sck;
	assign sck_pin_oe_n    = !((st_q.mode == baud_gen_pkg::MODE_THREE_WIRE)
		&& clk_sel_int); // R21
	assign transmit_enable = (st_q.mode == baud_gen_pkg::MODE_UART) &&
		st_q.async_mode[baud_gen_pkg::TX_EN_BIT]; // R16
	assign receive_enable  = (st_q.mode == baud_gen_pkg::MODE_UART) &&
		st_q.async_mode[baud_gen_pkg::RX_EN_BIT]; // R16
	assign first_bit_lsb   = st_q.sync_mode[baud_gen_pkg::BIT_ORDER_BIT];
	assign port_release    = (st_q.mode == baud_gen_pkg::MODE_STOPPED); // R13
	assign serial_mode     = st_q.mode;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_baud_byte_only;
		reg_wr_en && reg_wr_bit && reg_addr == baud_gen_pkg::ADDR_BAUD_SRC
			|=> $stable(st_q.baud_src);
	endproperty
	a_baud_byte_only: assert property (p_baud_byte_only) // R1
		else $error("bit write changed baud source select");

	// A tick is owed only if UART mode still held in the cycle before it
	property p_uart_div4;
		uart_x16_tick && serial_mode == baud_gen_pkg::MODE_UART &&
			st_q.baud_src == 8'h10 && !reg_wr_en
			|=> !uart_x16_tick [*3] ##1 (uart_x16_tick ||
			$past(serial_mode) != baud_gen_pkg::MODE_UART);
	endproperty
	a_uart_div4: assert property (p_uart_div4) // R8
		else $error("uart x16 tick spacing wrong for n=2");

	// Ticks are registered, so they follow the mode of the cycle before
	property p_no_uart_tick_3w;
		$past(serial_mode) != baud_gen_pkg::MODE_UART |->
			!uart_x16_tick && !uart_bit_tick;
	endproperty
	a_no_uart_tick_3w: assert property (p_no_uart_tick_3w) // R5
		else $error("uart tick outside uart mode");

	property p_ext_pin_tick;
		serial_mode == baud_gen_pkg::MODE_UART && src_code ==
			baud_gen_pkg::SRC_EXT_PIN && $past(serial_mode) ==
			baud_gen_pkg::MODE_UART && $past(src_code) ==
			baud_gen_pkg::SRC_EXT_PIN |-> uart_x16_tick == $past(ext_edge);
	endproperty
	a_ext_pin_tick: assert property (p_ext_pin_tick) // R9
		else $error("x16 tick does not follow pin edge");

	property p_sck_div4;
		sck_rise_tick && clk_sel_int && st_q.baud_src == 8'h00 && !reg_wr_en
			|=> (!sck_rise_tick || !$past(clk_sel_int)) [*3] ##1
			(sck_rise_tick || !$past(clk_sel_int) ||
			$past(serial_mode) != baud_gen_pkg::MODE_THREE_WIRE);
	endproperty
	a_sck_div4: assert property (p_sck_div4) // R10
		else $error("internal serial clock period wrong for n=1");

	property p_stopped_quiet;
		port_release |-> !transmit_enable && !receive_enable && sck_pin_oe_n
			&& (!$past(port_release) || (!uart_x16_tick && !sck_rise_tick));
	endproperty
	a_stopped_quiet: assert property (p_stopped_quiet) // R13
		else $error("activity in stopped mode");

	property p_mode_onehot;
		$onehot(serial_mode);
	endproperty
	a_mode_onehot: assert property (p_mode_onehot) // R12
		else $error("mode not one of three");

	property p_sync_bit_write;
		reg_wr_en && reg_wr_bit && reg_addr == baud_gen_pkg::ADDR_SYNC_MODE
			&& reg_bit_idx == 3'h7
			|=> st_q.sync_mode[7] == $past(reg_wr_data[0]);
	endproperty
	a_sync_bit_write: assert property (p_sync_bit_write) // R14
		else $error("3-wire enable bit write lost");

	property p_async_byte_write;
		reg_wr_en && !reg_wr_bit && reg_addr == baud_gen_pkg::ADDR_ASYNC_MODE
			|=> st_q.async_mode == $past(reg_wr_data);
	endproperty
	a_async_byte_write: assert property (p_async_byte_write) // R16
		else $error("async mode byte write lost");

	property p_oe_follows_sel;
		serial_mode == baud_gen_pkg::MODE_THREE_WIRE |->
			sck_pin_oe_n == !clk_sel_int;
	endproperty
	a_oe_follows_sel: assert property (p_oe_follows_sel) // R21
		else $error("serial clock pin drive disagrees with select");

	property p_single_pulse;
		uart_bit_tick || sck_fall_tick |=> !uart_bit_tick && !sck_fall_tick;
	endproperty
	a_single_pulse: assert property (p_single_pulse) // R22
		else $error("clock enable longer than one cycle");
endmodule : serial_baud_gen_and_mode_ctrl

// file: tb/serial_far_end.sv
// Far-end model: external UART clock source and 3-wire master clock
`timescale 1ns/1ps
module serial_far_end (
	output logic ext_clk,
	output logic sck
);
	// Both clocks stand still between bursts; the serial clock idles high
	initial begin
		ext_clk = 1'b0;
		sck     = 1'b1;
	end
	// The device only listens on this pin, so this model alone drives it
	task automatic ext_burst(input int n, input int half_ns);
		repeat (n) begin
			#(half_ns) ext_clk = 1'b1;
			#(half_ns) ext_clk = 1'b0;
		end
	endtask : ext_burst
	// External serial clock, falling edge first, slow enough to sync
	task automatic sck_burst(input int n);
		repeat (n) begin
			#50 sck = 1'b0;
			#50 sck = 1'b1;
		end
	endtask : sck_burst
endmodule : serial_far_end

// file: tb/test_serial_baud_gen_and_mode_ctrl.sv
// Self-checking bench of the baud generator and mode control block
`timescale 1ns/1ps
`define CHECK_EQ(nm, ex, got) begin samples_checked++; \
	if ((got) !== (ex)) begin fail_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module test_serial_baud_gen_and_mode_ctrl;
	localparam int LIMIT = 50000;
	localparam logic [15:0] A_AS = baud_gen_pkg::ADDR_ASYNC_MODE;
	localparam logic [15:0] A_SY = baud_gen_pkg::ADDR_SYNC_MODE;
	localparam logic [15:0] A_BR = baud_gen_pkg::ADDR_BAUD_SRC;
	logic        clk_sys, reset_n, wr_en, wr_bit, rd_en;
	logic [15:0] addr;
	logic [2:0]  idx, mode;
	logic [7:0]  wdata, rdata, d;
	logic        ext_pin, far_sck, sck_wire, sck_out, oe_n;
	logic        x16, bitt, rise, fall, tx_en, rx_en, lsb, rel;
	int          fail_count, samples_checked, cycles;
	int          n_x16, n_bit, n_rise, n_fall;

	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	// Pin level: the block wins only while its enable is low
	assign sck_wire = oe_n ? far_sck : sck_out;

	serial_baud_gen_and_mode_ctrl u_serial_baud_gen_and_mode_ctrl (
		.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(addr),
		.reg_wr_en(wr_en), .reg_wr_bit(wr_bit), .reg_bit_idx(idx),
		.reg_wr_data(wdata), .reg_rd_en(rd_en), .reg_rd_data(rdata),
		.ext_async_clock_pin(ext_pin), .sck_pin_in(sck_wire),
		.sck_pin_out(sck_out), .sck_pin_oe_n(oe_n), .uart_x16_tick(x16),
		.uart_bit_tick(bitt), .sck_rise_tick(rise), .sck_fall_tick(fall),
		.transmit_enable(tx_en), .receive_enable(rx_en),
		.first_bit_lsb(lsb), .port_release(rel), .serial_mode(mode));
	serial_far_end u_serial_far_end (.ext_clk(ext_pin), .sck(far_sck));

	// Tick counters and hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (x16 === 1'b1) n_x16++;
		if (bitt === 1'b1) n_bit++;
		if (rise === 1'b1) n_rise++;
		if (fall === 1'b1) n_fall++;
		if (cycles == LIMIT) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic wr(input logic [15:0] a, input logic [7:0] v,
		input logic b, input logic [2:0] i);
		@(negedge clk_sys);
		addr = a;
		wdata = v;
		wr_bit = b;
		idx = i;
		wr_en = 1'b1;
		@(negedge clk_sys);
		wr_en = 1'b0;
	endtask : wr
	// Read data stands one cycle, so it is sampled at the next fall
	task automatic rd(input logic [15:0] a, input logic [7:0] ex);
		@(negedge clk_sys);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk_sys);
		rd_en = 1'b0;
		`CHECK_EQ("read data", ex, rdata)
	endtask : rd
	// Let mode changes land before counting starts
	task automatic clear_counts;
		repeat (4) @(negedge clk_sys);
		{n_x16, n_bit, n_rise, n_fall} = '0;
	endtask : clear_counts
	task automatic window(input int n);
		clear_counts();
		repeat (n) @(negedge clk_sys);
	endtask : window
	function automatic int exp_ticks(input int code, input int win);
		return win >> (code + 1);
	endfunction : exp_ticks
	task automatic complete_run;
		$display("Checked %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run

	initial begin
		{reset_n, wr_en, wr_bit, rd_en, idx, wdata, addr} = '0;
		d = 8'($urandom(32'hF7B6));
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		rd(A_AS, 8'h00);
		rd(A_SY, 8'h00);
		rd(A_BR, 8'h00);
		`CHECK_EQ("mode", baud_gen_pkg::MODE_STOPPED, mode)
		`CHECK_EQ("release", 1'b1, rel)
		// Random values with reserved bits zero; traffic bits left off
		repeat (4) begin
			d = 8'($urandom) & 8'h3C;
			wr(A_AS, d, 1'b0, 3'h0);
			rd(A_AS, d);
			d = 8'($urandom) & 8'h06;
			wr(A_SY, d, 1'b0, 3'h0);
			rd(A_SY, d);
			`CHECK_EQ("first bit", d[2], lsb)
			// Code zero is kept out, as UART mode may follow
			d = {1'b0, 3'($urandom % 7) + 3'h1, 4'h0};
			wr(A_BR, d, 1'b0, 3'h0);
			rd(A_BR, d);
		end
		wr(A_BR, 8'h01, 1'b1, 3'h7);
		rd(A_BR, d);
		rd(16'hFF74, 8'h00);
		wr(A_SY, 8'h00, 1'b0, 3'h0);
		wr(A_SY, 8'h01, 1'b1, 3'h7);
		rd(A_SY, 8'h80);
		wr(A_SY, 8'h00, 1'b0, 3'h0);
		wr(A_AS, 8'h00, 1'b0, 3'h0);
		wr(A_AS, 8'h01, 1'b1, 3'h7);
		wr(A_AS, 8'h01, 1'b1, 3'h6);
		rd(A_AS, 8'hC0);
		// UART and 3-wire enables together fall back to stopped
		wr(A_SY, 8'h80, 1'b0, 3'h0);
		clear_counts();
		`CHECK_EQ("mixed mode", baud_gen_pkg::MODE_STOPPED, mode)
		wr(A_SY, 8'h00, 1'b0, 3'h0);
		// Internal UART codes 1 to 7; window spans two bit periods
		for (int c = 1; c < 8; c++) begin
			wr(A_AS, 8'h00, 1'b0, 3'h0);
			wr(A_BR, 8'(c << 4), 1'b0, 3'h0);
			wr(A_AS, 8'hC0, 1'b0, 3'h0);
			window(64 << c);
			`CHECK_EQ("x16 ticks", exp_ticks(c, 64 << c), n_x16)
			`CHECK_EQ("bit ticks", exp_ticks(c, 64 << c) / 16, n_bit)
			`CHECK_EQ("mode", baud_gen_pkg::MODE_UART, mode)
			`CHECK_EQ("tx rx", 2'b11, {tx_en, rx_en})
		end
		// Pin clock of 500 kHz gives two bits at 31.25 kbps
		wr(A_AS, 8'h00, 1'b0, 3'h0);
		wr(A_BR, {baud_gen_pkg::SRC_EXT_PIN, 4'h0}, 1'b0, 3'h0);
		wr(A_AS, 8'hC0, 1'b0, 3'h0);
		clear_counts();
		u_serial_far_end.ext_burst(32, 1000);
		repeat (8) @(negedge clk_sys);
		`CHECK_EQ("ext x16", 32, n_x16)
		`CHECK_EQ("ext bits", 2, n_bit)
		// Stopped: pin pulses must not reach the generator
		wr(A_AS, 8'h00, 1'b0, 3'h0);
		clear_counts();
		u_serial_far_end.ext_burst(8, 100);
		`CHECK_EQ("stopped x16", 0, n_x16)
		`CHECK_EQ("release", 1'b1, rel)
		// 3-wire with internal clock at the fastest code
		wr(A_BR, 8'h00, 1'b0, 3'h0);
		wr(A_SY, 8'h82, 1'b0, 3'h0);
		window(256);
		`CHECK_EQ("rise", exp_ticks(0, 256) / 2, n_rise)
		`CHECK_EQ("fall", exp_ticks(0, 256) / 2, n_fall)
		`CHECK_EQ("oe_n", 1'b0, oe_n)
		`CHECK_EQ("mode", baud_gen_pkg::MODE_THREE_WIRE, mode)
		// The pin clock code gives no serial clock in 3-wire mode
		wr(A_SY, 8'h00, 1'b0, 3'h0);
		wr(A_BR, 8'h80, 1'b0, 3'h0);
		wr(A_SY, 8'h82, 1'b0, 3'h0);
		clear_counts();
		u_serial_far_end.ext_burst(8, 100);
		`CHECK_EQ("ext 3-wire", 0, n_rise + n_fall)
		// Serial clock from the pin; source code left at a stray value
		wr(A_SY, 8'h00, 1'b0, 3'h0);
		wr(A_BR, 8'h30, 1'b0, 3'h0);
		wr(A_SY, 8'h80, 1'b0, 3'h0);
		clear_counts();
		u_serial_far_end.sck_burst(8);
		repeat (8) @(negedge clk_sys);
		`CHECK_EQ("pin rise", 8, n_rise)
		`CHECK_EQ("pin fall", 8, n_fall)
		`CHECK_EQ("oe_n", 1'b1, oe_n)
		complete_run();
	end
endmodule : test_serial_baud_gen_and_mode_ctrl
